//--- rtl/uc_pkg.sv
// constants shared by the two-channel uart pin signalling block
package uc_pkg;
  localparam int          CHANS          = 2;
  localparam int          FIFO_DEPTH     = 64;
  localparam int          CNT_W          = 7;
  localparam int          ADDR_W         = 8;
  // address map: paddr[5] picks the channel, paddr[4:0] the register
  localparam int          CHAN_BIT       = 5;
  localparam logic [4:0]  OFF_MODEM_CTRL = 5'h00;
  localparam logic [4:0]  OFF_MODEM_STAT = 5'h04;
  localparam logic [4:0]  OFF_ENH_FEAT   = 5'h08;
  localparam logic [4:0]  OFF_IRQ_EN     = 5'h0c;
  localparam logic [4:0]  OFF_TRIGGER    = 5'h10;
  localparam logic [4:0]  OFF_READY      = 5'h14;
  // modem control fields
  localparam int          MC_TERM_READY  = 0;
  localparam int          MC_REQ_SEND    = 1;
  localparam int          MC_IRQ_DRIVE   = 3;
  localparam int          MC_LOOPBACK    = 4;
  // enhanced feature, interrupt enable, modem status fields
  localparam int          EF_AUTO_RTS    = 6;
  localparam int          IE_RX_DATA     = 0;
  localparam int          IE_TX_EMPTY    = 1;
  localparam int          IE_MODEM       = 3;
  localparam int          MS_RING_EDGE   = 2;
  localparam int          MS_RING        = 6;
  // trigger register fields
  localparam int          TRIG_RX_LSB    = 0;
  localparam int          TRIG_TX_LSB    = 8;
  // values after reset, and the count of a full fifo
  localparam logic [7:0]  MODEM_CTRL_RST = 8'h00;
  localparam logic [7:0]  ENH_FEAT_RST   = 8'h00;
  localparam logic [7:0]  IRQ_EN_RST     = 8'h00;
  localparam logic [CNT_W-1:0] RX_TRIG_RST = 7'h08;
  localparam logic [CNT_W-1:0] TX_TRIG_RST = 7'h08;
  localparam logic [CNT_W-1:0] FIFO_FULL   = 7'h40;
endpackage : uc_pkg

//--- rtl/uc_ring_detect.sv
// ring indicator synchroniser and release-edge detector for one channel
`timescale 1ns/10ps
module uc_ring_detect
  import uc_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // pin and result
  input  wire logic ring_n_pin,
  output logic      ring_level_n,
  output logic      ring_rise
);
  logic ring_meta;
  logic ring_prev;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ring_meta    <= 1'b1;
      ring_level_n <= 1'b1;
      ring_prev    <= 1'b1;
    end
    else if (clk_en)
    begin
      ring_meta    <= ring_n_pin;
      ring_level_n <= ring_meta;
      ring_prev    <= ring_level_n;
    end
  end

  // edge taken only from synchronised copies, so one transition gives one pulse
  assign ring_rise = clk_en && ring_level_n && !ring_prev;

  single_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ring_rise |=> !ring_rise)
    else $error("ring edge pulse lasted more than one cycle");
endmodule : uc_ring_detect

//--- rtl/uc_dma_ready.sv
// receive-ready and transmit-ready handshake outputs for one channel
`timescale 1ns/10ps
module uc_dma_ready
  import uc_pkg::*;
(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  // receive side
  input  wire logic [CNT_W-1:0] rx_count,
  input  wire logic [CNT_W-1:0] rx_trig,
  input  wire logic             rx_timeout,
  input  wire logic             rx_error,
  // transmit side
  input  wire logic [CNT_W-1:0] tx_count,
  input  wire logic [CNT_W-1:0] tx_trig,
  // handshake outputs
  output logic                  rx_ready_n,
  output logic                  tx_ready_n
);
  logic             rx_release;
  logic             rx_claim;
  logic [CNT_W-1:0] tx_free;

  assign rx_release = (rx_count == '0) || rx_error;
  assign rx_claim   = (rx_count >= rx_trig) || rx_timeout;
  assign tx_free    = FIFO_FULL - tx_count;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_ready_n <= 1'b1;
    else if (clk_en)
    begin
      // empty or error wins over a trigger seen in the same cycle
      if (rx_release)
        rx_ready_n <= 1'b1;
      else if (rx_claim)
        rx_ready_n <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_ready_n <= 1'b1;
    else if (clk_en)
    begin
      if (tx_count >= FIFO_FULL)
        tx_ready_n <= 1'b1;
      else if (tx_free >= tx_trig)
        tx_ready_n <= 1'b0;
    end
  end

  rx_claim_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && rx_claim && !rx_release |=> !rx_ready_n)
    else $error("receive ready did not go low at trigger");
  rx_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && rx_release |=> rx_ready_n)
    else $error("receive ready did not return high");
  tx_claim_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && tx_count < FIFO_FULL && tx_free >= tx_trig |=> !tx_ready_n)
    else $error("transmit ready did not go low at trigger");
  tx_full_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && tx_count >= FIFO_FULL |=> tx_ready_n)
    else $error("transmit ready low while buffer full");
endmodule : uc_dma_ready

//--- rtl/uc_top.sv
// two-channel uart pin signalling: modem pins, loopback, dma handshakes, apb registers
//
// Operation
// - active reset returns all registers and outputs of both channels to initial state.
// - during reset serial output idles and serial input is not sampled.
// - each channel has its own independent modem, flow and serial signals.
// - rising edge on active-low ring input raises modem status interrupt if enabled.
// - ring input level is readable in the channel's modem status register.
// - modem control bit 1 set drives request-to-send low; clear drives it high.
// - request-to-send is high after reset.
// - request-to-send gates flow only when auto request-to-send feature bit is set.
// - loopback ignores serial input pin and feeds transmit data to receiver.
// - loopback disables the external serial output pin.
// - receive-ready goes low at receive trigger level or receive timeout.
// - receive-ready returns high when receive fifo empty or holds an error.
// - transmit-ready goes low when free transmit space reaches the trigger level.
// - transmit-ready goes high when the transmit buffer is full.
// - modem control bit 0 set drives terminal-ready low; clear or reset high.
// - interrupt output driven only with modem control bit 3 set; else released.
`timescale 1ns/10ps
module uc_top
  import uc_pkg::*;
(
  // clock, reset, enable
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // channel 0 pins
  input  wire logic              ring_indicator_n_chan0,
  input  wire logic              serial_in_chan0,
  output logic                   serial_out_chan0,
  output logic                   request_send_n_chan0,
  output logic                   terminal_ready_n_chan0,
  output logic                   receive_ready_n_chan0,
  output logic                   transmit_ready_n_chan0,
  output logic                   irq_out_chan0,
  output logic                   irq_oe_chan0,
  // channel 1 pins
  input  wire logic              ring_indicator_n_chan1,
  input  wire logic              serial_in_chan1,
  output logic                   serial_out_chan1,
  output logic                   request_send_n_chan1,
  output logic                   terminal_ready_n_chan1,
  output logic                   receive_ready_n_chan1,
  output logic                   transmit_ready_n_chan1,
  output logic                   irq_out_chan1,
  output logic                   irq_oe_chan1,
  // channel 0 core side
  input  wire logic              core_tx_chan0,
  output logic                   core_rx_chan0,
  input  wire logic [CNT_W-1:0]  rx_count_chan0,
  input  wire logic              rx_timeout_chan0,
  input  wire logic              rx_error_chan0,
  input  wire logic [CNT_W-1:0]  tx_count_chan0,
  // channel 1 core side
  input  wire logic              core_tx_chan1,
  output logic                   core_rx_chan1,
  input  wire logic [CNT_W-1:0]  rx_count_chan1,
  input  wire logic              rx_timeout_chan1,
  input  wire logic              rx_error_chan1,
  input  wire logic [CNT_W-1:0]  tx_count_chan1
);
  // ---------------------------------------------------------------------
  // per-channel views of the ports
  // ---------------------------------------------------------------------
  logic             ring_pin   [CHANS];
  logic             sin_pin    [CHANS];
  logic             core_tx    [CHANS];
  logic [CNT_W-1:0] rx_count   [CHANS];
  logic             rx_timeout [CHANS];
  logic             rx_error   [CHANS];
  logic [CNT_W-1:0] tx_count   [CHANS];
  logic             sout       [CHANS];
  logic             rts_n      [CHANS];
  logic             dtr_n      [CHANS];
  logic             rx_rdy_n   [CHANS];
  logic             tx_rdy_n   [CHANS];
  logic             irq_val    [CHANS];
  logic             irq_oe     [CHANS];
  logic             core_rx    [CHANS];

  assign ring_pin   = '{ring_indicator_n_chan0, ring_indicator_n_chan1};
  assign sin_pin    = '{serial_in_chan0, serial_in_chan1};
  assign core_tx    = '{core_tx_chan0, core_tx_chan1};
  assign rx_count   = '{rx_count_chan0, rx_count_chan1};
  assign rx_timeout = '{rx_timeout_chan0, rx_timeout_chan1};
  assign rx_error   = '{rx_error_chan0, rx_error_chan1};
  assign tx_count   = '{tx_count_chan0, tx_count_chan1};

  assign serial_out_chan0       = sout[0];
  assign serial_out_chan1       = sout[1];
  assign request_send_n_chan0   = rts_n[0];
  assign request_send_n_chan1   = rts_n[1];
  assign terminal_ready_n_chan0 = dtr_n[0];
  assign terminal_ready_n_chan1 = dtr_n[1];
  assign receive_ready_n_chan0  = rx_rdy_n[0];
  assign receive_ready_n_chan1  = rx_rdy_n[1];
  assign transmit_ready_n_chan0 = tx_rdy_n[0];
  assign transmit_ready_n_chan1 = tx_rdy_n[1];
  assign irq_out_chan0          = irq_val[0];
  assign irq_out_chan1          = irq_val[1];
  assign irq_oe_chan0           = irq_oe[0];
  assign irq_oe_chan1           = irq_oe[1];
  assign core_rx_chan0          = core_rx[0];
  assign core_rx_chan1          = core_rx[1];

  // ---------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------
  logic       sel_chan;
  logic [4:0] sel_off;
  logic       sel_ok;
  logic       acc_done;
  logic       wr_take;
  logic       rd_take;

  assign sel_chan = paddr[CHAN_BIT];
  assign sel_off  = paddr[4:0];
  assign sel_ok   = (paddr[ADDR_W-1:CHAN_BIT+1] == '0) &&
                    (sel_off == OFF_MODEM_CTRL || sel_off == OFF_MODEM_STAT ||
                     sel_off == OFF_ENH_FEAT || sel_off == OFF_IRQ_EN ||
                     sel_off == OFF_TRIGGER || sel_off == OFF_READY);
  assign acc_done = clk_en && psel && penable && pready;
  assign wr_take  = acc_done && pwrite && sel_ok;
  assign rd_take  = acc_done && !pwrite && sel_ok;

  // ---------------------------------------------------------------------
  // per-channel registers and pin logic
  // ---------------------------------------------------------------------
  logic [7:0]       modem_control_reg    [CHANS];
  logic [7:0]       enhanced_feature_reg [CHANS];
  logic [7:0]       interrupt_enable_reg [CHANS];
  logic [CNT_W-1:0] rx_trig              [CHANS];
  logic [CNT_W-1:0] tx_trig              [CHANS];
  logic             ring_edge            [CHANS];
  logic             ring_level_n         [CHANS];
  logic             ring_rise            [CHANS];
  logic [31:0]      chan_rdata           [CHANS];

  genvar c;
  generate
    for (c = 0; c < CHANS; c++)
    begin : g_chan
      logic wr_here;
      logic rx_at_trig;
      logic sin_meta;
      logic sin_sync;
      logic modem_irq;

      assign wr_here    = wr_take && (sel_chan == 1'(c));
      assign rx_at_trig = rx_count[c] >= rx_trig[c];
      assign modem_irq  = interrupt_enable_reg[c][IE_MODEM] && ring_edge[c];

      uc_ring_detect u_ring (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .clk_en       (clk_en),
        .ring_n_pin   (ring_pin[c]),
        .ring_level_n (ring_level_n[c]),
        .ring_rise    (ring_rise[c])
      );

      uc_dma_ready u_ready (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .rx_count   (rx_count[c]),
        .rx_trig    (rx_trig[c]),
        .rx_timeout (rx_timeout[c]),
        .rx_error   (rx_error[c]),
        .tx_count   (tx_count[c]),
        .tx_trig    (tx_trig[c]),
        .rx_ready_n (rx_rdy_n[c]),
        .tx_ready_n (tx_rdy_n[c])
      );

      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          modem_control_reg[c]    <= MODEM_CTRL_RST;
          enhanced_feature_reg[c] <= ENH_FEAT_RST;
          interrupt_enable_reg[c] <= IRQ_EN_RST;
          rx_trig[c]              <= RX_TRIG_RST;
          tx_trig[c]              <= TX_TRIG_RST;
        end
        else if (wr_here)
        begin
          unique case (sel_off)
            OFF_MODEM_CTRL: modem_control_reg[c]    <= pwdata[7:0];
            OFF_ENH_FEAT:   enhanced_feature_reg[c] <= pwdata[7:0];
            OFF_IRQ_EN:     interrupt_enable_reg[c] <= pwdata[7:0];
            OFF_TRIGGER:
            begin
              rx_trig[c] <= pwdata[TRIG_RX_LSB +: CNT_W];
              tx_trig[c] <= pwdata[TRIG_TX_LSB +: CNT_W];
            end
            default: ;
          endcase
        end
      end

      // sticky ring edge; a new edge beats a clearing status read
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          ring_edge[c] <= 1'b0;
        else if (ring_rise[c])
          ring_edge[c] <= 1'b1;
        else if (rd_take && sel_chan == 1'(c) && sel_off == OFF_MODEM_STAT)
          ring_edge[c] <= 1'b0;
      end

      // modem pins
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          rts_n[c]   <= 1'b1;
          dtr_n[c]   <= 1'b1;
          irq_oe[c]  <= 1'b0;
          irq_val[c] <= 1'b0;
        end
        else if (clk_en)
        begin
          // auto flow drops the request while the receive fifo sits at trigger
          rts_n[c]   <= !(modem_control_reg[c][MC_REQ_SEND] &&
                          !(enhanced_feature_reg[c][EF_AUTO_RTS] && rx_at_trig));
          dtr_n[c]   <= !modem_control_reg[c][MC_TERM_READY];
          irq_oe[c]  <= modem_control_reg[c][MC_IRQ_DRIVE];
          irq_val[c] <= modem_control_reg[c][MC_IRQ_DRIVE] &&
                        (modem_irq ||
                         (interrupt_enable_reg[c][IE_RX_DATA] && rx_at_trig) ||
                         (interrupt_enable_reg[c][IE_TX_EMPTY] && tx_count[c] == '0));
        end
      end

      // serial path; input pin synchronised, both ends idle high in reset
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sin_meta    <= 1'b1;
          sin_sync    <= 1'b1;
          sout[c]     <= 1'b1;
          core_rx[c]  <= 1'b1;
        end
        else if (clk_en)
        begin
          sin_meta <= sin_pin[c];
          sin_sync <= sin_meta;
          if (modem_control_reg[c][MC_LOOPBACK])
          begin
            sout[c]    <= 1'b1;
            core_rx[c] <= core_tx[c];
          end
          else
          begin
            sout[c]    <= core_tx[c];
            core_rx[c] <= sin_sync;  // relies on idle-high line
          end
        end
      end

      always_comb
      begin
        chan_rdata[c] = 32'h0000_0000;
        unique case (sel_off)
          OFF_MODEM_CTRL: chan_rdata[c][7:0] = modem_control_reg[c];
          OFF_MODEM_STAT:
          begin
            chan_rdata[c][MS_RING]      = !ring_level_n[c];
            chan_rdata[c][MS_RING_EDGE] = ring_edge[c];
          end
          OFF_ENH_FEAT:   chan_rdata[c][7:0] = enhanced_feature_reg[c];
          OFF_IRQ_EN:     chan_rdata[c][7:0] = interrupt_enable_reg[c];
          OFF_TRIGGER:
          begin
            chan_rdata[c][TRIG_RX_LSB +: CNT_W] = rx_trig[c];
            chan_rdata[c][TRIG_TX_LSB +: CNT_W] = tx_trig[c];
          end
          OFF_READY:
          begin
            chan_rdata[c][0] = rx_rdy_n[c];
            chan_rdata[c][1] = tx_rdy_n[c];
          end
          default: chan_rdata[c] = 32'h0000_0000;
        endcase
      end

      rts_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && modem_control_reg[c][MC_REQ_SEND] && !enhanced_feature_reg[c][EF_AUTO_RTS] |=> !rts_n[c])
        else $error("request-to-send not low with control bit set");
      auto_rts_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && enhanced_feature_reg[c][EF_AUTO_RTS] && rx_at_trig |=> rts_n[c])
        else $error("auto flow did not drop request-to-send");
      dtr_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en |=> dtr_n[c] == !$past(modem_control_reg[c][MC_TERM_READY]))
        else $error("terminal-ready does not follow control bit 0");
      irq_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !irq_oe[c] |-> !$past(modem_control_reg[c][MC_IRQ_DRIVE]) || !$past(clk_en))
        else $error("interrupt released while drive bit set");
      ring_event_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ring_rise[c] && interrupt_enable_reg[c][IE_MODEM] && modem_control_reg[c][MC_IRQ_DRIVE]
        ##1 clk_en && interrupt_enable_reg[c][IE_MODEM] && modem_control_reg[c][MC_IRQ_DRIVE] |=> irq_val[c])
        else $error("ring release did not raise interrupt");
      loop_tx_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && modem_control_reg[c][MC_LOOPBACK] |=> sout[c])
        else $error("serial output driven in loopback");
      loop_rx_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && modem_control_reg[c][MC_LOOPBACK] |=> core_rx[c] == $past(core_tx[c]))
        else $error("loopback did not feed transmit data to receiver");
      rts_reset_a: assert property (@(posedge ref_clk)
        !rst_n |-> rts_n[c] && dtr_n[c] && sout[c])
        else $error("pins not idle during reset");
    end
  endgenerate

  // ---------------------------------------------------------------------
  // apb answer: one wait-free access phase, data latched in setup
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !sel_ok;
      if (psel && !penable && !pwrite && sel_ok)
        prdata <= chan_rdata[sel_chan];
      else if (psel && !penable)
        prdata <= 32'h0000_0000;
    end
  end

  ring_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && psel && !penable && !pwrite && sel_ok && sel_off == OFF_MODEM_STAT
    |=> prdata[MS_RING] == !$past(sel_chan ? ring_level_n[1] : ring_level_n[0]))
    else $error("modem status ring bit wrong");
endmodule : uc_top

//--- tb/uc_line_peer.sv
// modem side peer: ring indicator and idle receive line for both channels
`timescale 1ns/10ps
module uc_line_peer
  import uc_pkg::*;
(
  // command from the bench
  input  wire logic [1:0] ring_cmd,
  // line side pins
  output logic            ring_n0,
  output logic            ring_n1,
  output logic            line0,
  output logic            line1
);
  // -----------------------------------------
  // one ring line per channel, active low
  // -----------------------------------------
  assign ring_n0 = ~ring_cmd[0];
  assign ring_n1 = ~ring_cmd[1];
  // no frames are ever sent, so both lines idle high
  assign line0 = 1'b1;
  assign line1 = 1'b1;
endmodule : uc_line_peer

//--- tb/uart_channel_pin_signalling_tb.sv
// self-checking bench for the uart pin signalling block
`timescale 1ns/10ps
module uart_channel_pin_signalling_tb;
  import uc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b1;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic [1:0]  ring_cmd = 2'h0, ctx = 2'h3, tmo = 2'h0, err = 2'h0;
  logic [6:0]  rxc0 = 7'h00, txc0 = 7'h00, rxc1 = 7'h00, txc1 = 7'h00;
  logic        pready, pslverr, e, ring0, ring1, ln0, ln1, so0, so1, rts0, rts1, dtr0, dtr1;
  logic        rr0, rr1, tr0, tr1, irq0, irq1, oe0, oe1, crx0, crx1;
  int          fails = 0;
  int          comparisons = 0;
  // -----------------------------------------
  // design, peer and test sequence
  // -----------------------------------------
  uc_line_peer peer (.ring_cmd(ring_cmd), .ring_n0(ring0), .ring_n1(ring1), .line0(ln0), .line1(ln1));
  uc_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ring_indicator_n_chan0(ring0), .serial_in_chan0(ln0), .serial_out_chan0(so0),
    .request_send_n_chan0(rts0), .terminal_ready_n_chan0(dtr0), .receive_ready_n_chan0(rr0),
    .transmit_ready_n_chan0(tr0), .irq_out_chan0(irq0), .irq_oe_chan0(oe0),
    .ring_indicator_n_chan1(ring1), .serial_in_chan1(ln1), .serial_out_chan1(so1),
    .request_send_n_chan1(rts1), .terminal_ready_n_chan1(dtr1), .receive_ready_n_chan1(rr1),
    .transmit_ready_n_chan1(tr1), .irq_out_chan1(irq1), .irq_oe_chan1(oe1),
    .core_tx_chan0(ctx[0]), .core_rx_chan0(crx0), .rx_count_chan0(rxc0), .rx_timeout_chan0(tmo[0]),
    .rx_error_chan0(err[0]), .tx_count_chan0(txc0), .core_tx_chan1(ctx[1]), .core_rx_chan1(crx1),
    .rx_count_chan1(rxc1), .rx_timeout_chan1(tmo[1]), .rx_error_chan1(err[1]), .tx_count_chan1(txc1));
  always #50 ref_clk = ~ref_clk;
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wt
  task automatic end_sim;
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  initial
  begin
    rst_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    wt(1);
    chk("reset0", {rts0, dtr0, oe0, irq0, so0, crx0}, 6'h33);
    apb(1'b1, 8'h00, 32'h0b);
    wt(2);
    chk("mctl", {rts0, dtr0, oe0, rts1, dtr1, oe1}, 6'h0e);
    apb(1'b1, 8'h0c, 32'h08);
    ring_cmd[0] <= 1'b1;
    wt(6);
    apb(1'b0, 8'h04, 32'h0);
    chk("ring_low", q & 32'h44, 32'h40);
    ring_cmd[0] <= 1'b0;
    wt(6);
    chk("irq_ring", {irq0, irq1}, 2'h2);
    apb(1'b0, 8'h04, 32'h0);
    chk("ring_edge", q & 32'h44, 32'h04);
    apb(1'b0, 8'h04, 32'h0);
    chk("ring_once", q & 32'h44, 32'h00);
    ctx[0] <= 1'b0;
    wt(3);
    chk("normal", {so0, crx0}, 2'h1);
    apb(1'b1, 8'h00, 32'h19);
    wt(3);
    chk("loop", {so0, crx0, rts0}, 3'h5);
    ctx[0] <= 1'b1;
    apb(1'b1, 8'h00, 32'h0b);
    apb(1'b1, 8'h08, 32'h40);
    rxc0 <= 7'h08;
    wt(3);
    chk("rx_trig", {rr0, rts0}, 2'h1);
    chk("chan1_idle", {so1, crx1, rr1}, 3'h7);
    rxc0 <= 7'h03;
    wt(3);
    chk("rx_hold", {rr0, rts0}, 2'h0);
    err[0] <= 1'b1;
    wt(3);
    chk("rx_err", rr0, 1'b1);
    err[0] <= 1'b0;
    tmo[0] <= 1'b1;
    wt(3);
    chk("rx_tmo", rr0, 1'b0);
    tmo[0] <= 1'b0;
    rxc0 <= 7'h00;
    wt(3);
    chk("rx_empty", rr0, 1'b1);
    txc0 <= FIFO_FULL;
    wt(3);
    chk("tx_full", {tr0, tr1}, 2'h2);
    txc0 <= 7'h3c;
    wt(3);
    chk("tx_hold", tr0, 1'b1);
    txc0 <= 7'h38;
    wt(3);
    chk("tx_trig", tr0, 1'b0);
    ce <= 1'b0;
    txc0 <= FIFO_FULL;
    wt(3);
    chk("freeze", tr0, 1'b0);
    ce <= 1'b1;
    wt(3);
    chk("thaw", tr0, 1'b1);
    apb(1'b0, 8'h14, 32'h0);
    chk("ready_rd", q, 32'h3);
    apb(1'b0, 8'h10, 32'h0);
    chk("trig_rd", q, 32'h0808);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", e, 1'b1);
    end_sim();
  end
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    end_sim();
  end
endmodule : uart_channel_pin_signalling_tb
